/* core/lmx_cfg.svh */
`ifndef LMX_CFG_SVH
`define LMX_CFG_SVH

// ==========================================================================
// command byte
`define LMX_CMD_RW_BIT      7
`define LMX_CMD_ID_MSB      6
`define LMX_CMD_ID_LSB      4
`define LMX_CMD_PAGE_MSB    3
`define LMX_CMD_PAGE_LSB    0
`define LMX_CHIP_ID         3'h5
`define LMX_PAGE_DUTY       4'h0
`define LMX_PAGE_SCALE      4'h1
`define LMX_PAGE_FUNC       4'h2

// ==========================================================================
// page layout
`define LMX_DOT_FIRST       8'h01
`define LMX_DOT_LAST        8'hc6
`define LMX_DOTS            198
`define LMX_COLS            18
`define LMX_ROWS            11
`define LMX_FN_CONFIG       8'h00
`define LMX_FN_GLOBAL       8'h01
`define LMX_FN_PULL         8'h02
`define LMX_FN_RES_FIRST    8'h03
`define LMX_FN_RES_LAST     8'h23
`define LMX_FN_THERMAL      8'h24
`define LMX_FN_SPREAD       8'h25
`define LMX_FN_RESET        8'h2f
`define LMX_RESET_KEY       8'hae
`define LMX_RES_BITS        6

// ==========================================================================
// configuration fields and reset values
`define LMX_CFG_ROWS_MSB    7
`define LMX_CFG_ROWS_LSB    4
`define LMX_CFG_TRIG_MSB    2
`define LMX_CFG_TRIG_LSB    1
`define LMX_CFG_RUN_BIT     0
`define LMX_ROWS_NOSCAN     4'ha
`define LMX_ROWS_MAXSEL     4'h9
`define LMX_TRIG_OPEN       2'h1
`define LMX_TRIG_SHORT      2'h2
`define LMX_CONFIG_RST      8'h00
`define LMX_GLOBAL_RST      8'h00
`define LMX_PULL_RST        8'h33
`define LMX_THERMAL_RST     8'h00
`define LMX_SPREAD_RST      8'h00
`define LMX_DOT_RST         8'h00

// ==========================================================================
// scan timing
`define LMX_CLK_MHZ         100
`define LMX_SCAN_NS         33000
`define LMX_BLANK_NS        830
`define LMX_DELAY_NS        300
`define LMX_SCAN_CYC        ((`LMX_SCAN_NS * `LMX_CLK_MHZ) / 1000)
`define LMX_BLANK_CYC       ((`LMX_BLANK_NS * `LMX_CLK_MHZ + 999) / 1000)
`define LMX_DELAY_CYC       ((`LMX_DELAY_NS * `LMX_CLK_MHZ + 999) / 1000)

`endif

/* core/lmx_pkg.sv */
package lmx_pkg;

    typedef enum logic [1:0] {
        LMX_PH_CMD,
        LMX_PH_ADDR,
        LMX_PH_DATA
    } lmx_phase_t;

    typedef enum logic [1:0] {
        LMX_SC_BLANK,
        LMX_SC_DELAY,
        LMX_SC_SCAN
    } lmx_scan_phase_t;

    typedef struct packed {
        lmx_scan_phase_t phase;
        logic [11:0]     cnt;
        logic [3:0]      row;
    } lmx_scan_t;

    typedef struct packed {
        logic [2:0]   sck_sync;
        logic [2:0]   cs_sync;
        logic [2:0]   mosi_sync;
        logic         sck_st;
        logic         cs_n_st;
        logic         mosi_st;
        lmx_phase_t   phase;
        logic [2:0]   bitcnt;
        logic         rd;
        logic         ign;
        logic [1:0]   page;
        logic [7:0]   ptr;
        logic [7:0]   rx;
        logic [7:0]   tx;
        logic         miso;
        logic         miso_oe_n;
        logic [7:0]   config_reg;
        logic [7:0]   global_cur;
        logic [7:0]   pull;
        logic [7:0]   thermal;
        logic [7:0]   spread;
        logic         armed;
        logic         det_act;
        logic         det_short;
        logic [197:0] results;
        logic [10:0]  row_sw;
        logic [17:0]  col_sink;
        logic [143:0] col_cur;
    } lmx_state_t;

endpackage

/* core/lmx_scan.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lmx_cfg.svh"

module lmx_scan
    import lmx_pkg::*;
#(
    parameter int SCAN_CYC  = `LMX_SCAN_CYC,
    parameter int BLANK_CYC = `LMX_BLANK_CYC,
    parameter int DELAY_CYC = `LMX_DELAY_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        run,
    input  wire logic        restart,
    input  wire logic [3:0]  rows,
    output logic      [3:0]  row,
    output logic             row_on,
    output logic             sink_on,
    output logic      [11:0] pos,
    output logic             row_end,
    output logic             frame_end
);

    lmx_scan_t q;
    lmx_scan_t n;

    assign row       = q.row;
    assign row_on    = run && (q.phase != LMX_SC_BLANK);
    assign sink_on   = run && (q.phase == LMX_SC_SCAN);
    assign pos       = q.cnt;
    assign row_end   = sink_on && (q.cnt == 12'(SCAN_CYC - 1));
    assign frame_end = row_end && (q.row == rows - 4'h1);

    // ==========================================================================
    // blank, sink delay, scan, then next row
    always_comb begin
        n = q;
        if (!run || restart) begin
            n.phase = LMX_SC_BLANK;
            n.cnt   = 12'h000;
            n.row   = 4'h0;
        end else begin
            n.cnt = q.cnt + 12'h001;
            case (q.phase)
                LMX_SC_BLANK: begin
                    if (q.cnt == 12'(BLANK_CYC - 1)) begin
                        n.phase = LMX_SC_DELAY;
                        n.cnt   = 12'h000;
                    end
                end
                LMX_SC_DELAY: begin
                    if (q.cnt == 12'(DELAY_CYC - 1)) begin
                        n.phase = LMX_SC_SCAN;
                        n.cnt   = 12'h000;
                    end
                end
                default: begin
                    if (q.cnt == 12'(SCAN_CYC - 1)) begin
                        n.phase = LMX_SC_BLANK;
                        n.cnt   = 12'h000;
                        // rows above the selected count are never visited
                        n.row   = (q.row >= rows - 4'h1) ? 4'h0 : q.row + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '{phase: LMX_SC_BLANK, cnt: 12'h000, row: 4'h0};
        end else begin
            q <= n;
        end
    end

endmodule

`default_nettype wire

/* core/lmx_top.sv */
// Contract
// - command byte: bit7 read/write, bits6:4 chip id 101, bits3:0 page.
// - serial input sampled on sck rising edges after chip select falls.
// - writes advance the register pointer by one after each data byte.
// - single read: command, address, then register shifted out on miso.
// - multi-read increments address at eighth rising edge of each byte.
// - commands 0x50, 0x51, 0x52 pick duty, scaling and function pages.
// - page 0 holds 198 duty bytes at 01h..c6h, reset zero.
// - each dot conducts value/256 of its row scan interval; during a detection pass every sink is on for the whole interval.
// - page 1 holds 198 current scale bytes at 01h..c6h, reset zero.
// - dot peak current is global/256 times dot scale/256.
// - row period: 33us scan, 0.83us blanking, 0.3us sink delay.
// - run bit zero keeps shutdown, one runs; reset gives shutdown. A detection pass scans even with the bit at zero.
// - row field scans eleven down to two rows; higher rows stay off.
// - row code 1010 stops scanning; sinks act as constant current only.
// - trigger 00/11 idle, 01 open detection, 10 short detection.
// - each trigger runs once; rearm by returning the field to 00.
// - function 01h global current, reset zero, scales all sinks.
// - function 03h..23h read-only detection results, reset zero.
// - pull register 02h resets to 0x33, others on page 2 to zero.
// - writing the reset register 2fh restores all power-on defaults.
// - the soft reset acts only for the value 0xae.
`timescale 1ns/1ps
`default_nettype none
`include "lmx_cfg.svh"

module lmx_top
    import lmx_pkg::*;
#(
    parameter int SCAN_CYC  = `LMX_SCAN_CYC,
    parameter int BLANK_CYC = `LMX_BLANK_CYC,
    parameter int DELAY_CYC = `LMX_DELAY_CYC
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         spi_sck,
    input  wire logic         spi_cs_n,
    input  wire logic         spi_mosi,
    output logic              spi_miso_out,
    output logic              spi_miso_oe_n,
    input  wire logic [17:0]  column_fault_sense,
    output logic      [10:0]  row_switch,
    output logic      [17:0]  column_sink,
    output logic      [143:0] column_current,
    output logic      [7:0]   pull_resistor_select,
    output logic      [7:0]   thermal_setting,
    output logic      [7:0]   spread_spectrum_setting,
    output logic              fault_detect_busy
);

    lmx_state_t q;
    lmx_state_t n;

    logic [7:0]  duty_page    [0:`LMX_DOTS-1];
    logic [7:0]  scaling_page [0:`LMX_DOTS-1];

    logic        mem_we;
    logic        mem_clear;
    logic        mem_sel_scale;
    logic [7:0]  mem_idx;
    logic [7:0]  mem_data;

    logic        sck_rise;
    logic        sck_fall;
    logic        det_start;
    logic        run;
    logic        noscan;
    logic [3:0]  rows;
    logic [3:0]  scan_row;
    logic        scan_row_on;
    logic        scan_sink_on;
    logic [11:0] scan_pos;
    logic        scan_row_end;
    logic        scan_frame_end;

    assign spi_miso_out            = q.miso;
    assign spi_miso_oe_n           = q.miso_oe_n;
    assign row_switch              = q.row_sw;
    assign column_sink             = q.col_sink;
    assign column_current          = q.col_cur;
    assign pull_resistor_select    = q.pull;
    assign thermal_setting         = q.thermal;
    assign spread_spectrum_setting = q.spread;
    assign fault_detect_busy       = q.det_act;

    // ==========================================================================
    // scan timebase
    wire [3:0] scan_row_select = q.config_reg[`LMX_CFG_ROWS_MSB:`LMX_CFG_ROWS_LSB];

    assign run    = q.config_reg[`LMX_CFG_RUN_BIT] || q.det_act;
    assign noscan = (scan_row_select == `LMX_ROWS_NOSCAN);
    // codes above 1010 are not allowed; they fall back to full eleven-row scan
    assign rows   = (scan_row_select <= `LMX_ROWS_MAXSEL) ? 4'(`LMX_ROWS) - scan_row_select : 4'(`LMX_ROWS);

    lmx_scan #(
        .SCAN_CYC  (SCAN_CYC),
        .BLANK_CYC (BLANK_CYC),
        .DELAY_CYC (DELAY_CYC)
    ) u_scan (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .run       (run && !noscan),
        .restart   (det_start),
        .rows      (rows),
        .row       (scan_row),
        .row_on    (scan_row_on),
        .sink_on   (scan_sink_on),
        .pos       (scan_pos),
        .row_end   (scan_row_end),
        .frame_end (scan_frame_end)
    );

    // ==========================================================================
    // register read view, used after the address byte and after each data byte
    function automatic logic [7:0] read_reg(input logic [1:0] page, input logic [7:0] addr);
        logic [7:0] val;
        logic [7:0] k;
        val = 8'h00;
        k   = addr - `LMX_FN_RES_FIRST;
        if (page != 2'(`LMX_PAGE_FUNC)) begin
            if (addr >= `LMX_DOT_FIRST && addr <= `LMX_DOT_LAST) begin
                val = (page == 2'(`LMX_PAGE_DUTY)) ? duty_page[addr - `LMX_DOT_FIRST]
                                                   : scaling_page[addr - `LMX_DOT_FIRST];
            end
        end else if (addr == `LMX_FN_CONFIG) begin
            val = q.config_reg;
        end else if (addr == `LMX_FN_GLOBAL) begin
            val = q.global_cur;
        end else if (addr == `LMX_FN_PULL) begin
            val = q.pull;
        end else if (addr >= `LMX_FN_RES_FIRST && addr <= `LMX_FN_RES_LAST) begin
            val = {2'b00, q.results[int'(k) * `LMX_RES_BITS +: `LMX_RES_BITS]};
        end else if (addr == `LMX_FN_THERMAL) begin
            val = q.thermal;
        end else if (addr == `LMX_FN_SPREAD) begin
            val = q.spread;
        end
        return val;
    endfunction

    // ==========================================================================
    // next state
    always_comb begin
        logic [7:0]  rxb;
        logic [7:0]  nxt_ptr;
        logic [1:0]  trig;
        logic [19:0] lhs;
        logic [19:0] rhs;
        logic [15:0] prod;
        logic [7:0]  dot;
        rxb           = 8'h00;
        nxt_ptr       = 8'h00;
        trig          = 2'b00;
        lhs           = 20'h00000;
        rhs           = 20'h00000;
        prod          = 16'h0000;
        dot           = 8'h00;
        n             = q;
        mem_we        = 1'b0;
        mem_clear     = 1'b0;
        mem_sel_scale = 1'b0;
        mem_idx       = 8'h00;
        mem_data      = 8'h00;
        det_start     = 1'b0;

        // pins: three stages, a level counts once stages two and three agree
        n.sck_sync  = {q.sck_sync[1:0], spi_sck};
        n.cs_sync   = {q.cs_sync[1:0], spi_cs_n};
        n.mosi_sync = {q.mosi_sync[1:0], spi_mosi};
        if (q.sck_sync[1] == q.sck_sync[2]) begin
            n.sck_st = q.sck_sync[2];
        end
        if (q.cs_sync[1] == q.cs_sync[2]) begin
            n.cs_n_st = q.cs_sync[2];
        end
        if (q.mosi_sync[1] == q.mosi_sync[2]) begin
            n.mosi_st = q.mosi_sync[2];
        end
        sck_rise = n.sck_st && !q.sck_st;
        sck_fall = !n.sck_st && q.sck_st;

        // ======================================================================
        // serial protocol
        if (q.cs_n_st) begin
            n.phase     = LMX_PH_CMD;
            n.bitcnt    = 3'h0;
            n.ign       = 1'b0;
            n.rd        = 1'b0;
            n.miso_oe_n = 1'b1;
        end else if (sck_rise) begin
            rxb      = {q.rx[6:0], q.mosi_st};
            n.rx     = rxb;
            n.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == 3'h7) begin
                nxt_ptr = q.ptr + 8'h01;
                case (q.phase)
                    LMX_PH_CMD: begin
                        n.rd    = rxb[`LMX_CMD_RW_BIT];
                        n.page  = rxb[1:0];
                        n.ign   = (rxb[`LMX_CMD_ID_MSB:`LMX_CMD_ID_LSB] != `LMX_CHIP_ID)
                               || (rxb[`LMX_CMD_PAGE_MSB:`LMX_CMD_PAGE_LSB] > `LMX_PAGE_FUNC);
                        n.phase = LMX_PH_ADDR;
                    end
                    LMX_PH_ADDR: begin
                        n.ptr   = rxb;
                        n.phase = LMX_PH_DATA;
                        if (q.rd) begin
                            n.tx = read_reg(q.page, rxb);
                        end
                    end
                    default: begin
                        n.ptr = nxt_ptr;
                        if (q.rd) begin
                            n.tx = read_reg(q.page, nxt_ptr);
                        end else if (!q.ign) begin
                            if (q.page != 2'(`LMX_PAGE_FUNC)) begin
                                if (q.ptr >= `LMX_DOT_FIRST && q.ptr <= `LMX_DOT_LAST) begin
                                    mem_we        = 1'b1;
                                    mem_sel_scale = (q.page == 2'(`LMX_PAGE_SCALE));
                                    mem_idx       = q.ptr - `LMX_DOT_FIRST;
                                    mem_data      = rxb;
                                end
                            end else if (q.ptr == `LMX_FN_CONFIG) begin
                                n.config_reg = rxb;
                            end else if (q.ptr == `LMX_FN_GLOBAL) begin
                                n.global_cur = rxb;
                            end else if (q.ptr == `LMX_FN_PULL) begin
                                n.pull = rxb;
                            end else if (q.ptr == `LMX_FN_THERMAL) begin
                                n.thermal = rxb;
                            end else if (q.ptr == `LMX_FN_SPREAD) begin
                                n.spread = rxb;
                            end else if (q.ptr == `LMX_FN_RESET && rxb == `LMX_RESET_KEY) begin
                                mem_clear    = 1'b1;
                                n.config_reg = `LMX_CONFIG_RST;
                                n.global_cur = `LMX_GLOBAL_RST;
                                n.pull       = `LMX_PULL_RST;
                                n.thermal    = `LMX_THERMAL_RST;
                                n.spread     = `LMX_SPREAD_RST;
                                n.results    = '0;
                                n.det_act    = 1'b0;
                                n.armed      = 1'b1;
                            end
                        end
                    end
                endcase
            end
        end else if (sck_fall && q.phase == LMX_PH_DATA && q.rd && !q.ign) begin
            // output moves only on falling edges so the host samples a settled bit
            n.miso      = q.tx[7];
            n.tx        = {q.tx[6:0], 1'b0};
            n.miso_oe_n = 1'b0;
        end

        // ======================================================================
        // open and short detection, one pass per arming
        trig = n.config_reg[`LMX_CFG_TRIG_MSB:`LMX_CFG_TRIG_LSB];
        if (trig != `LMX_TRIG_OPEN && trig != `LMX_TRIG_SHORT) begin
            n.armed = 1'b1;
        end else if (q.armed) begin
            n.armed     = 1'b0;
            n.det_act   = 1'b1;
            n.det_short = (trig == `LMX_TRIG_SHORT);
            n.results   = '0;
            det_start   = 1'b1;
        end else if (q.det_act && scan_row_end) begin
            n.results[int'(scan_row) * `LMX_COLS +: `LMX_COLS] = column_fault_sense;
            if (scan_frame_end) begin
                n.det_act = 1'b0;
            end
        end
        if (noscan && q.det_act) begin
            // without a scan there are no rows to visit, so the pass ends at once
            n.det_act = 1'b0;
        end

        // ======================================================================
        // row and column drive
        n.row_sw = (run && !noscan && scan_row_on) ? 11'(11'h001 << scan_row) : 11'h000;
        for (int c = 0; c < `LMX_COLS; c++) begin
            dot  = 8'(int'(noscan ? 4'h0 : scan_row) * `LMX_COLS + c);
            lhs  = 20'({scan_pos, 8'h00});
            rhs  = 20'(duty_page[dot] * 20'(SCAN_CYC));
            prod = q.global_cur * scaling_page[dot];
            if (!run) begin
                n.col_sink[c] = 1'b0;
            end else if (noscan) begin
                n.col_sink[c] = 1'b1;
            end else if (q.det_act) begin
                n.col_sink[c] = scan_sink_on;
            end else begin
                n.col_sink[c] = scan_sink_on && (lhs < rhs);
            end
            n.col_cur[c * 8 +: 8] = prod[15:8];
        end
    end

    // ==========================================================================
    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q            <= '0;
            q.sck_st     <= 1'b0;
            q.cs_n_st    <= 1'b1;
            q.cs_sync    <= 3'h7;
            q.miso_oe_n  <= 1'b1;
            q.phase      <= LMX_PH_CMD;
            q.config_reg <= `LMX_CONFIG_RST;
            q.global_cur <= `LMX_GLOBAL_RST;
            q.pull       <= `LMX_PULL_RST;
            q.thermal    <= `LMX_THERMAL_RST;
            q.spread     <= `LMX_SPREAD_RST;
            q.armed      <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ==========================================================================
    // dot memories; cleared by power-on and by the keyed soft reset
    always_ff @(posedge clk_sys) begin
        if (reset || mem_clear) begin
            for (int i = 0; i < `LMX_DOTS; i++) begin
                duty_page[i]    <= `LMX_DOT_RST;
                scaling_page[i] <= `LMX_DOT_RST;
            end
        end else if (mem_we) begin
            if (mem_sel_scale) begin
                scaling_page[mem_idx] <= mem_data;
            end else begin
                duty_page[mem_idx] <= mem_data;
            end
        end
    end

endmodule

`default_nettype wire

/* test/lmx_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// spi master, mode 0, msb first
module lmx_host (
    input  wire logic       clk_sys,
    input  wire logic       miso_out,
    input  wire logic       miso_oe_n,
    output logic            sck = 1'b0,
    output logic            cs_n = 1'b1,
    output logic            mosi = 1'b0,
    output logic            rx_stb = 1'b0,
    output logic      [7:0] rx_byte = 8'h00
);
    logic last = 1'b0;
    // a released line shows the inverse of its last level
    wire  line = miso_oe_n ? ~last : miso_out;
    always @(posedge clk_sys) begin
        if (!miso_oe_n) last <= miso_out;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // b: command, address, data; nrd bytes clocked in afterwards
    task automatic xfer(input logic [7:0] b[$], input int nrd);
        logic [7:0] v;
        logic [7:0] r;
        cs_n <= 1'b0;
        wt(8);
        for (int i = 0; i < b.size() + nrd; i++) begin
            v = (i < b.size()) ? b[i] : 8'h00;
            for (int k = 7; k >= 0; k--) begin
                mosi <= v[k];
                wt(8);
                sck <= 1'b1;
                r = {r[6:0], line};
                wt(8);
                sck <= 1'b0;
            end
            if (i >= b.size()) begin
                rx_byte <= r;
                rx_stb <= 1'b1;
                wt(1);
                rx_stb <= 1'b0;
            end
        end
        wt(8);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        wt(10);
    endtask
endmodule
`default_nettype wire

/* test/lmx_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// port checks of the serial output, register resets, row scan and detection start
module lmx_top_sva (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        spi_sck,
    input wire logic        spi_cs_n,
    input wire logic        spi_miso_out,
    input wire logic        spi_miso_oe_n,
    input wire logic [10:0] row_switch,
    input wire logic [17:0] column_sink,
    input wire logic [7:0]  pull_resistor_select,
    input wire logic [7:0]  thermal_setting,
    input wire logic        fault_detect_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // eight cycles outlast the sync chain and the write latency
    sequence s_idle;
        spi_cs_n [*8];
    endsequence
    sequence s_sck_high;
        (!spi_cs_n && spi_sck) [*8];
    endsequence
    oe_release_a: assert property (s_idle |-> spi_miso_oe_n)
        else $error("miso driven");
    miso_hold_a: assert property (s_sck_high |=> $stable(spi_miso_out))
        else $error("miso moved");
    pull_reset_a: assert property ($fell(reset) |-> pull_resistor_select == 8'h33)
        else $error("pull reset");
    out_reset_a: assert property ($fell(reset) |-> row_switch == 11'h0 && thermal_setting == 8'h00)
        else $error("outputs reset");
    row_onehot_a: assert property ($onehot0(row_switch))
        else $error("rows overlap");
    row_gap_a: assert property ($changed(row_switch) && row_switch != 11'h0 |-> $past(row_switch) == 11'h0)
        else $error("no blanking");
    sink_delay_a: assert property ($changed(row_switch) && row_switch != 11'h0 |-> column_sink == 18'h0)
        else $error("no sink delay");
    reg_quiet_a: assert property (s_idle |=> $stable(thermal_setting) && $stable(pull_resistor_select))
        else $error("register moved");
    detect_start_a: assert property ($rose(fault_detect_busy) |-> ##[1:20] row_switch == 11'h1)
        else $error("scan restart");
endmodule
bind lmx_top lmx_top_sva u_lmx_top_sva (.clk_sys(clk_sys), .reset(reset), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n),
    .row_switch(row_switch), .column_sink(column_sink), .pull_resistor_select(pull_resistor_select),
    .thermal_setting(thermal_setting), .fault_detect_busy(fault_detect_busy));
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// register page bench
module tb;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [17:0] fs = 18'h0;
    wire         sck, cs_n, mosi, miso, oe_n, stb, busy;
    wire  [7:0]  rxb, pull, therm, spr;
    wire  [10:0] rsw;
    wire  [17:0] csk;
    wire  [143:0] cur;
    logic [10:0] seen = 11'h0;
    int          n_errors = 0;
    int          n_checks = 0;
    int          seed = 32'h4cfe9470;
    logic [7:0]  q[$];
    logic [7:0]  d[2];
    always #5 clk_sys = ~clk_sys;
    lmx_top #(.SCAN_CYC(40), .BLANK_CYC(3), .DELAY_CYC(2)) u_lmx_top (.clk_sys(clk_sys), .reset(reset),
        .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_out(miso), .spi_miso_oe_n(oe_n),
        .column_fault_sense(fs), .row_switch(rsw), .column_sink(csk), .column_current(cur),
        .pull_resistor_select(pull), .thermal_setting(therm), .spread_spectrum_setting(spr),
        .fault_detect_busy(busy));
    lmx_host u_lmx_host (.clk_sys(clk_sys), .miso_out(miso), .miso_oe_n(oe_n), .sck(sck),
        .cs_n(cs_n), .mosi(mosi), .rx_stb(stb), .rx_byte(rxb));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] v);
        u_lmx_host.xfer({c, a, v}, 0);
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] e[$]);
        q = {q, e};
        u_lmx_host.xfer({c, a}, e.size());
    endtask
    task automatic wait_busy(input logic v);
        for (int i = 0; i < 1000 && busy !== v; i++) @(posedge clk_sys);
        cmp({7'h0, busy}, {7'h0, v});
    endtask
    always @(posedge clk_sys) begin
        if (stb === 1'b1) cmp(rxb, (q.size() > 0) ? q.pop_front() : 8'hxx);
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
        cmp(pull, 8'h33);
        d[0] = 8'($random(seed));
        d[1] = 8'($random(seed));
        u_lmx_host.xfer({8'h52, 8'h24, d[0], d[1]}, 0);
        cmp(therm, d[0]);
        cmp(spr, d[1]);
        wr(8'h52, 8'h23, 8'hff);
        rd(8'hd2, 8'h23, {8'h00, d[0], d[1]});
        rd(8'hd2, 8'h02, {8'h33});
        for (int p = 0; p < 2; p++) begin
            wr(8'(8'h50 + p), 8'hc6, d[p]);
            rd(8'(8'hd0 + p), 8'hc6, {d[p]});
        end
        wr(8'h32, 8'h24, ~d[0]);
        wr(8'h53, 8'h24, ~d[0]);
        wr(8'h52, 8'h2f, 8'h12);
        cmp(therm, d[0]);
        wr(8'h52, 8'h2f, 8'hae);
        cmp(therm, 8'h00);
        rd(8'hd0, 8'hc6, {8'h00});
        fs <= 18'($random(seed));
        wr(8'h52, 8'h01, 8'h0f);
        wr(8'h52, 8'h00, 8'h0b);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(8'hd2, 8'h03, {8'(fs[5:0]), 8'(fs[11:6]), 8'(fs[17:12])});
        wr(8'h52, 8'h00, 8'h09);
        wr(8'h52, 8'h00, 8'h0d);
        wait_busy(1'b1);
        wr(8'h51, 8'h01, 8'h80);
        wr(8'h52, 8'h00, 8'ha9);
        repeat (20) @(posedge clk_sys);
        cmp(rsw[7:0], 8'h00);
        cmp(csk[7:0], 8'hff);
        // without scan the row is fixed at zero, so column 0 shows dot 01h: 0x0f * 0x80 / 256
        cmp(cur[7:0], 8'h07);
        wr(8'h52, 8'h00, 8'h99);
        repeat (300) begin
            @(posedge clk_sys);
            seen = seen | rsw;
        end
        cmp({5'h0, seen[2:0]}, 8'h03);
        cmp(seen[10:3], 8'h00);
        wr(8'h52, 8'h00, 8'h08);
        repeat (20) @(posedge clk_sys);
        cmp(csk[7:0], 8'h00);
        close_out();
    end
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
